//--- hw/rtc_indirect_defines.vh
// constants for the clock-core indirect access port
// assumes an 8-bit special-function-register bus from the processor core
`ifndef RTC_INDIRECT_DEFINES_VH
`define RTC_INDIRECT_DEFINES_VH

// ----------------------------------------------------------------
// core-side register offsets and reset values
// ----------------------------------------------------------------
`define IADDR_SEL_OFS     8'hAC
`define IDATA_PORT_OFS    8'hAD
`define LOCK_STATUS_OFS   8'hAE
`define IADDR_SEL_RST     8'h00
`define IADDR_FIELD_RST   5'h00
`define IDATA_PORT_RST    8'h00
`define LOCK_UNLOCKED_VAL 8'h02

// ----------------------------------------------------------------
// address select fields
// ----------------------------------------------------------------
`define AUTO_RD_BIT       6
`define ADDR_MSB          4

// ----------------------------------------------------------------
// internal address map
// ----------------------------------------------------------------
`define INT_CAP_FIRST     5'h00
`define INT_CAP_LAST      5'h03
`define INT_CORE_CTRL     5'h04
`define INT_OSC_CTRL      5'h05
`define INT_OSC_CFG       5'h06
`define INT_ALARM_CFG     5'h07
`define INT_ALM_FIRST     5'h08
`define INT_ALM_LAST      5'h13

// ----------------------------------------------------------------
// internal register fields
// ----------------------------------------------------------------
`define CC_PWR_EN_BIT     7
`define CC_OSC_FAIL_BIT   5
`define CC_LFO_EN_BIT     3
`define CC_TMR_SET_BIT    1
`define CC_TMR_CAP_BIT    0
`define OC_GAIN_EN_BIT    7
`define OC_MODE_BIT       6
`define OC_BIAS_X2_BIT    5
`define OC_CLK_VLD_BIT    4
`define CFG_LOAD_RDY_BIT  7
`define CFG_LOAD_MSB      3
`define INT_REG_RST       8'h00

`endif

//--- hw/rtc_indirect_access.v
// indirect access port to the clock-core registers, plus oscillator controls
// assumes sfr strobes and timebase tick are synchronous to i_mclk
`timescale 1ns/1ps
`default_nettype none
`include "rtc_indirect_defines.vh"

module rtc_indirect_access (
  input  wire        i_mclk,
  input  wire        i_rst_b,
  input  wire [7:0]  i_sfr_addr,
  input  wire        i_sfr_wr,
  input  wire        i_sfr_rd,
  input  wire [7:0]  i_sfr_wdata,
  output wire [7:0]  o_sfr_rdata,
  input  wire        i_timebase_tick,
  input  wire        i_osc_stable,
  input  wire        i_load_cap_ready,
  input  wire        i_osc_fail,
  output wire        o_osc_power_en,
  output wire        o_osc_mode_crystal,
  output wire        o_gain_ctrl_en,
  output wire        o_bias_double_en,
  output wire        o_low_freq_en,
  output wire [3:0]  o_load_cap,
  output wire [31:0] o_timer
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function is_group;
    input [4:0] a;
    begin
      is_group = (a <= `INT_CAP_LAST) || ((a >= `INT_ALM_FIRST) && (a <= `INT_ALM_LAST));
    end
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg  [4:0]  addr_q;
  reg         auto_rd_q;
  reg  [7:0]  data_q;
  reg         launch_q;
  reg  [7:0]  rdata_q;
  reg  [7:0]  core_ctrl_q;
  reg  [7:0]  osc_ctrl_q;
  reg  [7:0]  osc_cfg_q;
  reg  [7:0]  alarm_cfg_q;
  reg  [31:0] timer_q;
  reg  [7:0]  grp_q [0:19];
  reg  [7:0]  int_rdata;
  reg  [7:0]  sfr_rmux;
  wire        clk_valid;
  wire        wr_addr;
  wire        wr_data;
  wire        rd_data;
  wire [4:0]  grp_idx;
  wire [4:0]  addr_inc;
  integer     k;

  assign wr_addr  = i_sfr_wr && (i_sfr_addr == `IADDR_SEL_OFS);
  assign wr_data  = i_sfr_wr && (i_sfr_addr == `IDATA_PORT_OFS);
  assign rd_data  = i_sfr_rd && (i_sfr_addr == `IDATA_PORT_OFS);
  assign addr_inc = addr_q + 5'd1;
  // capture bytes map to 0..3, alarm bytes to 8..19 of the group array
  assign grp_idx  = addr_q;

  assign clk_valid = osc_ctrl_q[`OC_BIAS_X2_BIT] & i_osc_stable;

  // ----------------------------------------------------------------
  // internal read mux
  // ----------------------------------------------------------------
  // internal address map
  always @* begin
    int_rdata = 8'h00;
    if (is_group(addr_q)) begin
      int_rdata = grp_q[grp_idx];
    end else if (addr_q == `INT_CORE_CTRL) begin
      int_rdata = core_ctrl_q;
      int_rdata[`CC_OSC_FAIL_BIT] = i_osc_fail;
    end else if (addr_q == `INT_OSC_CTRL) begin
      int_rdata = osc_ctrl_q;
      int_rdata[`OC_CLK_VLD_BIT] = clk_valid;
    end else if (addr_q == `INT_OSC_CFG) begin
      int_rdata = osc_cfg_q;
      int_rdata[`CFG_LOAD_RDY_BIT] = i_load_cap_ready;
    end else if (addr_q == `INT_ALARM_CFG) begin
      int_rdata = alarm_cfg_q;
    end
  end

  // ----------------------------------------------------------------
  // core-side read mux
  // ----------------------------------------------------------------
  always @* begin
    sfr_rmux = 8'h00;
    if (i_sfr_addr == `IADDR_SEL_OFS) begin
      sfr_rmux = {1'b0, auto_rd_q, 1'b0, addr_q};
    end else if (i_sfr_addr == `IDATA_PORT_OFS) begin
      sfr_rmux = data_q;
    end else if (i_sfr_addr == `LOCK_STATUS_OFS) begin
      sfr_rmux = `LOCK_UNLOCKED_VAL;
    end
  end

  always @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata_q <= 8'h00;
    end else if (i_sfr_rd) begin
      rdata_q <= sfr_rmux;
    end
  end

  // ----------------------------------------------------------------
  // indirect address, data and launch
  // ----------------------------------------------------------------
  always @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      addr_q    <= `IADDR_FIELD_RST;
      auto_rd_q <= 1'b0;
      data_q    <= `IDATA_PORT_RST;
      launch_q  <= 1'b0;
    end else begin
      launch_q <= 1'b0;
      // lock writes fall through, no key needed
      if (wr_addr) begin
        addr_q    <= i_sfr_wdata[`ADDR_MSB:0];
        auto_rd_q <= i_sfr_wdata[`AUTO_RD_BIT];
        launch_q  <= 1'b1;
      end else if (wr_data) begin
        data_q <= i_sfr_wdata;
        if (is_group(addr_q)) begin
          addr_q <= addr_inc;
        end
      end else if (rd_data && auto_rd_q) begin
        launch_q <= 1'b1;
      end else if (launch_q) begin
        data_q <= int_rdata;
        if (is_group(addr_q)) begin
          addr_q <= addr_inc;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // internal registers and timer
  // ----------------------------------------------------------------
  // timebase arrives as a synchronous tick, one domain only
  always @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      core_ctrl_q <= `INT_REG_RST;
      osc_ctrl_q  <= `INT_REG_RST;
      osc_cfg_q   <= `INT_REG_RST;
      alarm_cfg_q <= `INT_REG_RST;
      timer_q     <= 32'h0000_0000;
      for (k = 0; k < 20; k = k + 1) begin
        grp_q[k] <= 8'h00;
      end
    end else begin
      core_ctrl_q[`CC_TMR_SET_BIT] <= 1'b0;
      core_ctrl_q[`CC_TMR_CAP_BIT] <= 1'b0;
      if (i_timebase_tick && (core_ctrl_q[`CC_PWR_EN_BIT] || core_ctrl_q[`CC_LFO_EN_BIT])) begin
        timer_q <= timer_q + (core_ctrl_q[`CC_LFO_EN_BIT] ? 32'h0000_0002 : 32'h0000_0001);
      end
      if (core_ctrl_q[`CC_TMR_SET_BIT]) begin
        timer_q <= {grp_q[3], grp_q[2], grp_q[1], grp_q[0]};
      end
      if (core_ctrl_q[`CC_TMR_CAP_BIT]) begin
        {grp_q[3], grp_q[2], grp_q[1], grp_q[0]} <= timer_q;
      end
      if (wr_data) begin
        if (is_group(addr_q)) begin
          grp_q[grp_idx] <= i_sfr_wdata;
        end else if (addr_q == `INT_CORE_CTRL) begin
          core_ctrl_q <= i_sfr_wdata & 8'hDF;
        end else if (addr_q == `INT_OSC_CTRL) begin
          osc_ctrl_q <= i_sfr_wdata & 8'hEF;
        end else if (addr_q == `INT_OSC_CFG) begin
          osc_cfg_q <= i_sfr_wdata & 8'h7F;
        end else if (addr_q == `INT_ALARM_CFG) begin
          alarm_cfg_q <= i_sfr_wdata;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_sfr_rdata        = rdata_q;
  // power and low-frequency enables steer the analog oscillator rate
  assign o_osc_power_en     = core_ctrl_q[`CC_PWR_EN_BIT];
  assign o_osc_mode_crystal = osc_ctrl_q[`OC_MODE_BIT];
  assign o_gain_ctrl_en     = osc_ctrl_q[`OC_GAIN_EN_BIT];
  assign o_bias_double_en   = osc_ctrl_q[`OC_BIAS_X2_BIT];
  assign o_low_freq_en      = core_ctrl_q[`CC_LFO_EN_BIT];
  assign o_load_cap         = osc_cfg_q[`CFG_LOAD_MSB:0];
  assign o_timer            = timer_q;

endmodule // rtc_indirect_access
`default_nettype wire

//--- dv/rtc_indirect_checker.sv
// port assertions for the indirect access block
// assumes a single i_mclk domain; bound onto every block instance
`timescale 1ns/1ps
`default_nettype none
module rtc_indirect_checker (
  input wire logic        i_mclk,
  input wire logic        i_rst_b,
  input wire logic [7:0]  i_sfr_addr,
  input wire logic        i_sfr_wr,
  input wire logic        i_sfr_rd,
  input wire logic [7:0]  i_sfr_wdata,
  input wire logic        i_timebase_tick,
  input wire logic [7:0]  o_sfr_rdata,
  input wire logic        o_osc_power_en,
  input wire logic        o_gain_ctrl_en,
  input wire logic        o_bias_double_en,
  input wire logic        o_low_freq_en,
  input wire logic [31:0] o_timer
);
  // ------------------------------------------------
  // sequences and assertions
  // ------------------------------------------------
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  sequence s_sel(logic [4:0] a);
    i_sfr_wr && i_sfr_addr == 8'hAC && i_sfr_wdata[4:0] == a;
  endsequence
  sequence s_dwr;
    i_sfr_wr && i_sfr_addr == 8'hAD;
  endsequence
  a_lock_reads_two: assert property (i_sfr_rd && i_sfr_addr == 8'hAE |=> o_sfr_rdata == 8'h02)
    else $error("lock status read not 0x02");
  a_rdata_holds: assert property (!i_sfr_rd |=> $stable(o_sfr_rdata))
    else $error("read data moved without a read");
  a_resv_bits_zero: assert property (i_sfr_rd && i_sfr_addr == 8'hAC |=> !o_sfr_rdata[7] && !o_sfr_rdata[5])
    else $error("address select bit 7 or 5 read as one");
  a_auto_bit_kept: assert property (i_sfr_wr && i_sfr_addr == 8'hAC ##2 i_sfr_rd && i_sfr_addr == 8'hAC
    |=> o_sfr_rdata[6] == $past(i_sfr_wdata[6], 3)) else $error("auto read enable not kept");
  a_power_written: assert property (s_sel(5'h04) ##1 s_dwr |=> o_osc_power_en == $past(i_sfr_wdata[7]))
    else $error("power enable not written");
  a_osc_ctl_written: assert property (s_sel(5'h05) ##1 s_dwr |=>
    {o_gain_ctrl_en, o_bias_double_en} == {$past(i_sfr_wdata[7]), $past(i_sfr_wdata[5])})
    else $error("oscillator control not written");
  a_vld_forced_low: assert property (s_sel(5'h05) ##1 !i_sfr_wr ##1 (i_sfr_rd &&
    i_sfr_addr == 8'hAD && !o_bias_double_en) |=> !o_sfr_rdata[4]) else $error("clock valid high without bias");
  a_lfo_steps_two: assert property (o_low_freq_en && !o_osc_power_en && i_timebase_tick && !i_sfr_wr &&
    !$past(i_sfr_wr) |=> o_timer == $past(o_timer) + 32'h0000_0002)
    else $error("timer step not two");
  a_timer_idle: assert property (!o_osc_power_en && !o_low_freq_en && !i_sfr_wr && !$past(i_sfr_wr)
    |=> $stable(o_timer)) else $error("timer moved while stopped");
endmodule  // rtc_indirect_checker
bind rtc_indirect_access rtc_indirect_checker u_chk (.*);
`default_nettype wire

//--- dv/rtc_osc_model.sv
// far-side oscillator model: timebase tick and start-up flags
// assumes the power and low-frequency enables of the block
`timescale 1ns/1ps
`default_nettype none
module rtc_osc_model #(
  parameter int TICK_DIV = 4,
  parameter int SETTLE   = 20
) (
  input  wire logic i_mclk,
  input  wire logic i_rst_b,
  input  wire logic i_power_en,
  input  wire logic i_lfo_en,
  output wire logic o_tick,
  output wire logic o_stable,
  output wire logic o_load_ready,
  output wire logic o_fail
);
  // ------------------------------------------------
  // timebase and start-up
  // ------------------------------------------------
  int cnt = 0;
  int age = 0;
  wire logic        run = i_power_en | i_lfo_en;
  wire logic [31:0] div = i_power_en ? TICK_DIV : 2 * TICK_DIV;
  always @(posedge i_mclk) begin
    cnt <= (!i_rst_b || !run || cnt == div - 1) ? 0 : cnt + 1;
    age <= (!i_rst_b || !i_power_en) ? 0 : age + 1;
  end
  assign o_tick = run && cnt == div - 1;
  assign o_stable = age >= SETTLE;
  assign o_load_ready = age >= SETTLE + 8;
  assign o_fail = i_power_en && !o_stable;
endmodule  // rtc_osc_model
`default_nettype wire

//--- dv/rtc_indirect_access_tb_top.sv
// self-checking bench for the indirect access block
// assumes the oscillator model on the far side and the bound checker
`timescale 1ns/1ps
`default_nettype none
module rtc_indirect_access_tb_top;
  logic        i_mclk = 1'b0;
  logic        i_rst_b = 1'b1;
  logic        i_sfr_wr = 1'b0;
  logic        i_sfr_rd = 1'b0;
  logic [7:0]  i_sfr_addr = 8'h00;
  logic [7:0]  i_sfr_wdata = 8'h00;
  logic [7:0]  o_sfr_rdata, rv;
  logic        i_timebase_tick, i_osc_stable, i_load_cap_ready, i_osc_fail;
  logic        o_osc_power_en, o_osc_mode_crystal, o_gain_ctrl_en, o_bias_double_en, o_low_freq_en;
  logic [3:0]  o_load_cap;
  logic [31:0] o_timer, t0;
  int          fails = 0;
  int          check_count = 0;
  always #20 i_mclk = ~i_mclk;
  rtc_indirect_access uut (.*);
  rtc_osc_model part (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_power_en(o_osc_power_en),
    .i_lfo_en(o_low_freq_en), .o_tick(i_timebase_tick), .o_stable(i_osc_stable),
    .o_load_ready(i_load_cap_ready), .o_fail(i_osc_fail));
  // ------------------------------------------------
  // bus tasks
  // ------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    i_sfr_wr <= 1'b1;
    i_sfr_addr <= a;
    i_sfr_wdata <= d;
    @(posedge i_mclk);
  endtask
  task automatic idle();
    i_sfr_wr <= 1'b0;
    @(posedge i_mclk);
  endtask
  task automatic get(input logic [7:0] a);
    i_sfr_wr <= 1'b0;
    i_sfr_rd <= 1'b1;
    i_sfr_addr <= a;
    @(posedge i_mclk);
    i_sfr_rd <= 1'b0;
    @(posedge i_mclk);
    #1 rv = o_sfr_rdata;
    @(posedge i_mclk);
  endtask
  task automatic peek(input logic [7:0] a);
    put(8'hAC, a);
    idle();
    get(8'hAD);
  endtask
  task automatic poll(input logic [7:0] a, input int b);
    rv = 8'h00;
    for (int n = 0; n < 60 && rv[b] !== 1'b1; n++)
      peek(a);
    chk(rv[b], 1'b1);
  endtask
  // ------------------------------------------------
  // scenarios
  // ------------------------------------------------
  task automatic t_lock();
    get(8'hAE);
    chk(rv, 8'h02);
    get(8'hAD);
    chk(rv, 8'h00);
    put(8'hAE, 8'h55);
    get(8'hAE);
    chk(rv, 8'h02);
    put(8'hAC, 8'hFF);
    idle();
    get(8'hAC);
    chk(rv, 8'h5F);
  endtask
  task automatic t_groups();
    logic [7:0] b;
    for (int g = 0; g < 4; g++) begin
      b = (g == 0) ? 8'h00 : 8'h04 + 8'h04 * g[7:0];
      put(8'hAC, b);
      for (int k = 0; k < 4; k++)
        put(8'hAD, 8'hA0 + b + k[7:0]);
      put(8'hAC, 8'h40 | b);
      idle();
      for (int k = 0; k < 4; k++) begin
        get(8'hAD);
        chk(rv, 8'hA0 + b + k[7:0]);
      end
      get(8'hAC);
      chk(rv, 8'h40 | ((g == 0) ? 8'h04 : (g == 3) ? 8'h14 : b + 8'h05));
    end
  endtask
  task automatic t_no_auto();
    put(8'hAC, 8'h07);
    put(8'hAD, 8'h3C);
    peek(8'h07);
    chk(rv, 8'h3C);
    get(8'hAD);
    chk(rv, 8'h3C);
  endtask
  task automatic t_osc();
    put(8'hAC, 8'h05);
    put(8'hAD, 8'h60);
    put(8'hAC, 8'h06);
    put(8'hAD, 8'h0A);
    put(8'hAC, 8'h04);
    put(8'hAD, 8'h80);
    idle();
    #1 chk({o_osc_power_en, o_osc_mode_crystal, o_gain_ctrl_en, o_bias_double_en, o_load_cap}, 8'hDA);
    @(posedge i_mclk);
    peek(8'h04);
    chk(rv, 8'hA0);
    poll(8'h05, 4);
    poll(8'h06, 7);
    put(8'hAC, 8'h05);
    put(8'hAD, 8'hC0);
    peek(8'h05);
    chk(rv, 8'hC0);
    chk({o_gain_ctrl_en, o_bias_double_en}, 2'b10);
    chk(o_timer != 32'h0000_0000, 1'b1);
  endtask
  task automatic t_lfo();
    put(8'hAC, 8'h05);
    put(8'hAD, 8'h00);
    put(8'hAC, 8'h04);
    put(8'hAD, 8'h08);
    idle();
    #1 t0 = o_timer;
    chk(o_osc_mode_crystal, 1'b0);
    chk({o_low_freq_en, o_osc_power_en}, 2'b10);
    repeat (40) @(posedge i_mclk);
    #1 chk({o_timer[0], o_timer != t0}, {t0[0], 1'b1});
    @(posedge i_mclk);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    #1 i_rst_b = 1'b0;
    repeat (8) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    @(posedge i_mclk);
    t_lock();
    t_groups();
    t_no_auto();
    t_osc();
    t_lfo();
    tally_and_finish();
  end
  initial begin
    #200_000;
    fails++;
    tally_and_finish();
  end
endmodule  // rtc_indirect_access_tb_top
`default_nettype wire
